//--- flash_cmd.v
// serial flash command interpreter: ids, security areas, reset, suspend/resume
// Contract
// - identification read shifts out 24 stored bits on falling clock edges
// - chip select rise ends the id read; device returns to standby
// - id is manufacturer byte, then memory type byte, then capacity byte
// - unique id read: command, zero address, dummy, then 128-bit fixed value
// - two separate 1024-byte security areas, erased and programmed individually
// - area chosen by address bits 15..12; bits 9..0 pick byte
// - security erase needs latch set and select rise right after last address bit
// - valid erase/program starts timed cycle; busy high, latch cleared before end
// - lock bit set means erase and program of areas are ignored
// - security program: command, three address bytes, one or more data bytes
// - security read: command, address, dummy, then data on falling edges
// - read address increments per byte, low ten bits wrap to zero
// - reset needs enable-reset frame followed directly by reset frame
// - accepted reset aborts work and clears volatile state
// - commands refused during reset recovery
// - pause accepted only during program or erase with busy set, flag clear
// - pause sets flag at once, clears busy within the latency
// - program paused: reject status write, security ops, erases, page programs
// - erase paused: reject status write, security erase, all erases
// - continue accepted only when pause flag set and busy clear
// - continue clears flag at once, raises busy within 200 ns
// - security program runs timed cycle reported through busy flag
`include "flash_cmd_defines.vh"
module flash_cmd #(
  parameter [23:0]  id_value    = 24'hA55A01,   // arbitrary value
  parameter [127:0] unique_id   = 128'h0123456789ABCDEF0F1E2D3C4B5A6978, // arbitrary
  parameter         prog_cyc    = 100,
  parameter         erase_cyc   = 400,
  parameter         rst_cyc     = 50
) (
  // clock and reset
  input  wire       mclk,
  input  wire       arst_n,
  // serial link pins
  input  wire       cs_n,
  input  wire       sclk,
  input  wire       si,
  output reg        so,
  output reg        so_oe,
  // main array operation status
  input  wire       array_op_start,
  input  wire       array_op_is_erase,
  input  wire       array_op_done,
  input  wire       write_enable_set,
  input  wire       otp_lock_bit0,
  input  wire       otp_lock_bit1,
  // status
  output reg        write_in_progress,
  output reg        write_enable_latch,
  output reg        paused_op_flag,
  output reg        paused_is_erase,
  output reg        reset_busy,
  output reg        soft_reset_pulse
);
  localparam S_IDLE = 3'b001;
  localparam S_SEC  = 3'b010;
  localparam [31:0] SUSP_N = `SUSPEND_CYC;
  localparam [31:0] RES_N  = `RESUME_CYC;
  localparam PW = 8;

  // two-flop synchronisers for pins
  reg [1:0] cs_s, ck_s, si_s;
  reg       ck_d;
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_s <= 2'h3;
      ck_s <= 2'h0;
      si_s <= 2'h0;
      ck_d <= 1'b0;
    end
    else
    begin
      cs_s <= {cs_s[0], cs_n};
      ck_s <= {ck_s[0], sclk};
      si_s <= {si_s[0], si};
      ck_d <= ck_s[1];
    end
  end
  wire sel   = ~cs_s[1];
  wire rise  = sel & ck_s[1] & ~ck_d;
  wire fall  = sel & ~ck_s[1] & ck_d;

  // chip select edge detect on the synchronised level
  reg cs_d;
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      cs_d <= 1'b1;
    else
      cs_d <= cs_s[1];
  end
  wire cs_up = cs_s[1] & ~cs_d;

  // security area storage: two areas side by side
  reg [7:0] sec_mem [0:2*`SEC_AREA_BYTES-1];

  reg [7:0]  cmd;
  reg [31:0] sh;
  reg [10:0] bits;           // bits received this frame
  reg [7:0]  outsh;
  reg [2:0]  obit;
  reg [9:0]  rd_addr;
  reg        rd_area;
  reg [6:0]  uid_idx;
  reg [4:0]  id_idx;
  reg        rst_armed;
  reg        rst_arm_frame;
  reg [2:0]  op_state;
  reg [15:0] op_cnt;
  reg        op_erase;
  reg        op_area;
  reg [9:0]  pg_addr;
  reg [7:0]  pg_data [0:PW-1];
  reg [3:0]  pg_cnt;
  reg [3:0]  pg_i;
  reg [15:0] rcnt;
  reg [3:0]  susp_cnt;
  reg [3:0]  res_cnt;
  reg        arr_running;
  reg        adr_ok;         // address fields name a legal security area

  wire [7:0]  cmd_now  = {sh[6:0], si_s[1]};
  wire [31:0] sh_now   = {sh[30:0], si_s[1]};
  wire        addr_ok  = (sh_now[23:16] == 8'h00) & (sh_now[11:10] == 2'b00) &
    ((sh_now[15:12] == `SEC_AREA_SEL0) | (sh_now[15:12] == `SEC_AREA_SEL1));
  wire        locked   = otp_lock_bit0 | otp_lock_bit1;
  wire        prog_sus = paused_op_flag & ~paused_is_erase;
  wire        sec_ok   = write_enable_latch & ~locked & adr_ok &
                         ~paused_op_flag & (op_state == S_IDLE) & ~arr_running;
  integer k;

  // main frame, output and operation engine
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd <= 8'h00; sh <= 32'h0; bits <= 11'h0; outsh <= 8'h00; obit <= 3'h0;
      rd_addr <= 10'h0; rd_area <= 1'b0; uid_idx <= 7'h0; id_idx <= 5'h0;
      rst_armed <= 1'b0; rst_arm_frame <= 1'b0; op_state <= S_IDLE;
      op_cnt <= 16'h0; op_erase <= 1'b0; op_area <= 1'b0; pg_addr <= 10'h0;
      pg_cnt <= 4'h0; pg_i <= 4'h0; rcnt <= 16'h0; susp_cnt <= 4'h0; res_cnt <= 4'h0;
      arr_running <= 1'b0; so <= 1'b0; so_oe <= 1'b0; adr_ok <= 1'b0;
      write_in_progress <= 1'b0; write_enable_latch <= 1'b0;
      paused_op_flag <= 1'b0; paused_is_erase <= 1'b0;
      reset_busy <= 1'b0; soft_reset_pulse <= 1'b0;
    end
    else
    begin
      soft_reset_pulse <= 1'b0;
      if (reset_busy)
      begin
        // refuse everything until recovery counted out
        so_oe <= 1'b0;
        bits  <= 11'h0;
        if (rcnt == 16'h0)
          reset_busy <= 1'b0;
        else
          rcnt <= rcnt - 16'h1;
      end
      else
      begin
        if (write_enable_set)
          write_enable_latch <= 1'b1;
        // external main array program/erase tracking
        if (array_op_start & ~write_in_progress & ~paused_op_flag)
        begin
          arr_running <= 1'b1;
          op_erase <= array_op_is_erase;
          write_in_progress <= 1'b1;
        end
        if (arr_running & array_op_done & write_in_progress)
        begin
          arr_running <= 1'b0;
          write_in_progress <= 1'b0;
          write_enable_latch <= 1'b0;
        end
        // pause and continue latency: busy drops a few cycles after the flag rises, rises a few cycles after it falls
        if (susp_cnt != 4'h0)
        begin
          susp_cnt <= susp_cnt - 4'h1;
          if (susp_cnt == 4'h1)
            write_in_progress <= 1'b0;
        end
        if (res_cnt != 4'h0)
        begin
          res_cnt <= res_cnt - 4'h1;
          if (res_cnt == 4'h1)
            write_in_progress <= 1'b1;
        end
        // frame bit reception on rising clock
        if (rise)
        begin
          sh <= sh_now;
          if (bits != 11'h7FF)
            bits <= bits + 11'h1;
          if (bits == 11'd7)
          begin
            cmd <= cmd_now;
            id_idx <= 5'h0;
            uid_idx <= 7'h0;
          end
          if (bits == 11'd31) // latched before data bytes shift the address out
          begin
            adr_ok <= addr_ok;
            rd_area <= sh_now[12];
            rd_addr <= sh_now[9:0];
            if (cmd == `CMD_SEC_PROG && op_state == S_IDLE)
              pg_addr <= sh_now[9:0];
          end
          // program data collected one byte at a time
          if (cmd == `CMD_SEC_PROG && bits >= 11'd32 && bits[2:0] == 3'd7 &&
              pg_cnt != PW[3:0] && op_state == S_IDLE)
          begin
            pg_data[pg_cnt[2:0]] <= sh_now[7:0];
            pg_cnt <= pg_cnt + 4'h1;
          end
        end
        // output on falling clock
        if (fall)
        begin
          if (cmd == `CMD_IDREAD && bits >= 11'd8 && bits < 11'd32)
          begin
            so <= id_value[5'd23 - id_idx];
            so_oe <= 1'b1;
            id_idx <= id_idx + 5'h1;
          end
          else if (cmd == `CMD_UIDREAD && bits >= 11'd40 && bits < 11'd168)
          begin
            so <= unique_id[7'd127 - uid_idx];
            so_oe <= 1'b1;
            uid_idx <= uid_idx + 7'h1;
          end
          else if (cmd == `CMD_SEC_READ && bits >= 11'd40)
          begin
            so <= (obit == 3'h0) ? sec_mem[{rd_area, rd_addr}][7] : outsh[7];
            outsh <= (obit == 3'h0) ? {sec_mem[{rd_area, rd_addr}][6:0], 1'b0}
                                    : {outsh[6:0], 1'b0};
            so_oe <= 1'b1;
            obit <= obit + 3'h1;
            if (obit == 3'h7)
              rd_addr <= rd_addr + 10'h1;
          end
        end
        // frame end: decode by length, exact except for security program frames of 40 or more whole-byte bits
        if (cs_up)
        begin
          so_oe <= 1'b0;
          bits <= 11'h0;
          obit <= 3'h0;
          pg_cnt <= 4'h0;
          rst_armed <= 1'b0;
          if (bits == 11'd8 && cmd == `CMD_RST_EN)
            rst_armed <= 1'b1;
          if (bits == 11'd8 && cmd == `CMD_RST && rst_armed)
          begin
            // abort everything, back to power-on defaults
            reset_busy <= 1'b1;
            rcnt <= rst_cyc[15:0];
            soft_reset_pulse <= 1'b1;
            op_state <= S_IDLE; arr_running <= 1'b0;
            write_in_progress <= 1'b0; write_enable_latch <= 1'b0;
            paused_op_flag <= 1'b0; paused_is_erase <= 1'b0;
            susp_cnt <= 4'h0; res_cnt <= 4'h0;
          end
          if (bits == 11'd8 && cmd == `CMD_PAUSE && arr_running &&
              write_in_progress && !paused_op_flag && susp_cnt == 4'h0)
          begin
            paused_op_flag <= 1'b1;
            paused_is_erase <= op_erase;
            susp_cnt <= SUSP_N[3:0];
          end
          if (bits == 11'd8 && cmd == `CMD_CONTINUE && paused_op_flag &&
              !write_in_progress)
          begin
            paused_op_flag <= 1'b0;
            res_cnt <= RES_N[3:0];
          end
          if (bits == 11'd32 && cmd == `CMD_SEC_ERASE)
          begin
            if (sec_ok)
            begin
              op_state <= S_SEC;
              op_erase <= 1'b1;
              op_area <= sh[12];
              op_cnt <= erase_cyc[15:0];
              write_in_progress <= 1'b1;
            end
            else
              write_enable_latch <= 1'b0;
          end
          if (bits >= 11'd40 && bits[2:0] == 3'd0 && cmd == `CMD_SEC_PROG &&
              !prog_sus)
          begin
            if (sec_ok)
            begin
              op_state <= S_SEC;
              op_erase <= 1'b0;
              op_area <= rd_area;
              pg_i <= pg_cnt;
              op_cnt <= prog_cyc[15:0];
              write_in_progress <= 1'b1;
            end
            else
              write_enable_latch <= 1'b0;
          end
        end
        // self-timed security cycle
        case (op_state)
          S_IDLE: ;
          S_SEC:
          begin
            if (op_cnt == 16'd2)
              write_enable_latch <= 1'b0;
            if (op_cnt == 16'h0)
            begin
              write_in_progress <= 1'b0;
              op_state <= S_IDLE;
            end
            else
              op_cnt <= op_cnt - 16'h1;
          end
          default: op_state <= S_IDLE;
        endcase
      end
    end
  end

  // memory write port: erase and program bytes, AND-ing programmed data
  reg [10:0] ers_i;
  reg        ers_go;
  always @(posedge mclk)
  begin
    if (op_state == S_SEC && op_cnt == 16'd1 && !op_erase)
      for (k = 0; k < PW; k = k + 1)
        if (k < pg_i)
          sec_mem[{op_area, pg_addr[9:3], 3'h0} + {pg_addr[2:0] + k[2:0]}] <=
            sec_mem[{op_area, pg_addr[9:3], 3'h0} + {pg_addr[2:0] + k[2:0]}] & pg_data[k];
    if (ers_go)
      sec_mem[{op_area, ers_i[9:0]}] <= 8'hFF;
  end

  // erase walks the area one byte per cycle, stopping after byte 1023 or when the cycle ends
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ers_i <= 11'h0;
      ers_go <= 1'b0;
    end
    else if (op_state == S_SEC && op_erase && op_cnt == erase_cyc[15:0])
    begin
      ers_i <= 11'h0;
      ers_go <= 1'b1;
    end
    else if (ers_go)
    begin
      ers_i <= ers_i + 11'h1;
      if (ers_i == 11'd1023 || op_state != S_SEC)
        ers_go <= 1'b0;
    end
  end
endmodule

//--- flash_cmd_assertions.sv
// checker for the flash command interpreter, bound to its ports
module flash_cmd_assertions (
  // clock and reset
  input logic mclk,
  input logic arst_n,
  // pins and status seen at the ports
  input logic cs_n,
  input logic so_oe,
  input logic array_op_done,
  input logic write_in_progress,
  input logic write_enable_latch,
  input logic paused_op_flag,
  input logic reset_busy,
  input logic soft_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // all checks sample on the system clock and rest while reset is low
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  pause_needs_busy_a: assert property (
    $rose(paused_op_flag) |-> $past(write_in_progress)) else $error("pause taken while idle");
  pause_drops_busy_a: assert property (
    $rose(paused_op_flag) |-> ##[0:5] !write_in_progress) else $error("busy kept after pause");
  resume_needs_idle_a: assert property (
    $fell(paused_op_flag) && !reset_busy && !soft_reset_pulse |-> !$past(write_in_progress))
    else $error("continue taken while busy");
  resume_raises_busy_a: assert property (
    $fell(paused_op_flag) && !reset_busy && !soft_reset_pulse |-> ##[0:6] write_in_progress)
    else $error("busy not back after continue");
  // array completions are excluded: the latch is only owed for the timed cycles here
  latch_clear_end_a: assert property (
    $fell(write_in_progress) && !paused_op_flag && !$past(array_op_done)
    && !$past(array_op_done, 2) |-> !write_enable_latch) else $error("latch set at cycle end");
  reset_clears_a: assert property (
    soft_reset_pulse |-> ##[0:2] !(paused_op_flag || write_enable_latch || write_in_progress))
    else $error("state kept after reset");
  recovery_refuses_a: assert property (
    reset_busy && $past(reset_busy) |-> !soft_reset_pulse && !$rose(paused_op_flag))
    else $error("command taken in recovery");
  idle_output_off_a: assert property (
    cs_n [*8] |=> !so_oe) else $error("output driven while deselected");
endmodule
bind flash_cmd flash_cmd_assertions i_flash_cmd_assertions (.mclk(mclk), .arst_n(arst_n),
  .cs_n(cs_n), .so_oe(so_oe), .array_op_done(array_op_done),
  .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
  .paused_op_flag(paused_op_flag), .reset_busy(reset_busy),
  .soft_reset_pulse(soft_reset_pulse));

//--- flash_cmd_defines.vh
// constants for the serial flash command interpreter
`ifndef FLASH_CMD_DEFINES_VH
`define FLASH_CMD_DEFINES_VH
`define CMD_WRITE_ENABLE_COMMAND_CODE   8'h06
`define CMD_WRSR        8'h01
`define CMD_PP          8'h02
`define CMD_QPP         8'h32
`define CMD_SE          8'h20
`define CMD_BE32        8'h52
`define CMD_BE64        8'hD8
`define CMD_CE1         8'h60
`define CMD_CE2         8'hC7
`define CMD_IDREAD      8'h9F
`define CMD_UIDREAD     8'h4B
`define CMD_SEC_ERASE   8'h44
`define CMD_SEC_PROG    8'h42
`define CMD_SEC_READ    8'h48
`define CMD_RST_EN      8'h66
`define CMD_RST         8'h99
`define CMD_PAUSE       8'h75
`define CMD_CONTINUE    8'h7A
`define SEC_AREA_BYTES  1024
`define SEC_AREA_SEL0   4'h0
`define SEC_AREA_SEL1   4'h1
`define CLK_PERIOD_NS   40
`define RESUME_MAX_NS   200
`define RESUME_CYC      ((`RESUME_MAX_NS / `CLK_PERIOD_NS) < 1 ? 1 : (`RESUME_MAX_NS / `CLK_PERIOD_NS))
`define SUSPEND_CYC     4
`endif

//--- spi_host_model.sv
// host serial controller model that drives command frames, mode 0
module spi_host_model (
  // link pins
  output logic cs_n,
  output logic sclk,
  output logic si,
  input  logic so
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int half = 160; // half of the 320 ns link period
  // ntx bits out msb first, then nrx bits in; clock parks low between frames
  task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
                       output logic [127:0] rx);
    rx = 128'h0;
    cs_n = 1'b0;
    #(half);
    for (int i = ntx + nrx - 1; i >= 0; i--)
    begin
      // released data line toggles so a stale level is never mistaken for data
      si = (i >= nrx) ? tx[i - nrx] : ~si;
      #(half) sclk = 1'b1;
      if (i < nrx)
        rx[i] = so;
      #(half) sclk = 1'b0;
    end
    #(half) cs_n = 1'b1;
    si = ~si;
    #(4 * half);
  endtask
  // idle pins from time zero
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
endmodule

//--- testbench.sv
// self-checking bench for the flash command interpreter
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0]  id_val  = 24'hC35A17; // arbitrary value
  localparam logic [127:0] uid_val = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0; // arbitrary value
  // clock, reset and link pins
  logic         mclk   = 1'b0;
  logic         arst_n = 1'b0;
  logic         cs_n, sclk, si, so, so_oe;
  // a released output shows the inverse of its last bit, so stale data never passes
  logic         so_line;
  assign so_line = so_oe ? so : ~so;
  // array side inputs and status outputs
  logic         array_op_start = 1'b0, array_op_is_erase = 1'b0, array_op_done = 1'b0;
  logic         write_enable_set = 1'b0, otp_lock_bit0 = 1'b0, otp_lock_bit1 = 1'b0;
  logic         write_in_progress, write_enable_latch, paused_op_flag, paused_is_erase;
  logic         reset_busy, soft_reset_pulse;
  logic [127:0] rx;
  int           mismatches = 0, n_tests = 0, n_rst = 0;
  // 25 MHz system clock
  always #20 mclk = ~mclk;
  // device under test and the host driving it; short program count keeps the run brief, erase count spans a whole area
  flash_cmd #(.id_value(id_val), .unique_id(uid_val), .prog_cyc(20), .erase_cyc(1100),
    .rst_cyc(150)) i_flash_cmd (.mclk, .arst_n, .cs_n, .sclk, .si, .so, .so_oe,
    .array_op_start, .array_op_is_erase, .array_op_done, .write_enable_set,
    .otp_lock_bit0, .otp_lock_bit1, .write_in_progress, .write_enable_latch,
    .paused_op_flag, .paused_is_erase, .reset_busy, .soft_reset_pulse);
  spi_host_model i_spi_host_model (.cs_n, .sclk, .si, .so(so_line));
  // accepted resets, the pulse lasts one cycle only
  always @(posedge mclk)
    if (soft_reset_pulse === 1'b1)
      n_rst++;
  task automatic check_val(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // status bits: recovery, erase paused, paused, busy, latch
  function automatic logic [127:0] st();
    return {123'h0, reset_busy, paused_is_erase, paused_op_flag, write_in_progress,
            write_enable_latch};
  endfunction
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  task automatic send(input logic [63:0] tx, input int ntx, input int nrx);
    i_spi_host_model.frame(tx, ntx, nrx, rx);
    step();
  endtask
  // 0 sets the latch, 1 starts an array operation, 2 finishes it
  task automatic pulse(input int which);
    step();
    case (which)
      0: write_enable_set = 1'b1;
      1: array_op_start = 1'b1;
      default: array_op_done = 1'b1;
    endcase
    step();
    {write_enable_set, array_op_start, array_op_done} = 3'h0;
    repeat (4) step();
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (write_in_progress !== 1'b0 && k < 2000)
    begin
      step();
      k++;
    end
    if (k >= 2000)
      mismatches++;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    repeat (4) step();
    send(64'h9F, 8, 24);
    check_val(rx, {104'h0, id_val});
    check_val(so_oe, 128'h0);
    send(64'h9F, 8, 10);
    check_val(rx, {118'h0, id_val[23:14]});
    send(64'h4B00000000, 40, 128);
    check_val(rx, uid_val);
    send(64'h42000000A5, 40, 0);
    check_val(st(), 128'h0);
    // one bit too many discards the erase, the exact frame runs it
    pulse(0);
    send(64'h88000000, 33, 0);
    check_val(st(), 128'h1);
    send(64'h44000000, 32, 0);
    check_val(st() & 128'h2, 128'h2);
    wait_idle();
    check_val(st(), 128'h0);
    // programs on both sides of the wrap, then one read across it
    pulse(0);
    send(64'h420003FEA55A, 48, 0);
    check_val(st() & 128'h2, 128'h2);
    wait_idle();
    pulse(0);
    send(64'h420000003CC3, 48, 0);
    wait_idle();
    check_val(st(), 128'h0);
    send(64'h480003FE00, 40, 48);
    check_val(rx, 128'hA55A3CC3FFFF);
    // locked areas ignore erase and program
    otp_lock_bit0 = 1'b1;
    otp_lock_bit1 = 1'b1;
    pulse(0);
    send(64'h44000000, 32, 0);
    check_val(st() & 128'h2, 128'h0);
    send(64'h4200000000, 40, 0);
    check_val(st() & 128'h2, 128'h0);
    send(64'h4800000000, 40, 16);
    check_val(rx, 128'h3CC3);
    otp_lock_bit0 = 1'b0;
    otp_lock_bit1 = 1'b0;
    // paused program refuses a security program; continue only when paused
    pulse(1);
    send(64'h75, 8, 0);
    check_val(st() & 128'h6, 128'h4);
    pulse(0);
    send(64'h4200000000, 40, 0);
    check_val(st() & 128'h6, 128'h4);
    send(64'h7A, 8, 0);
    check_val(st() & 128'h6, 128'h2);
    pulse(2);
    send(64'h7A, 8, 0);
    check_val(st() & 128'h6, 128'h0);
    send(64'h75, 8, 0);
    check_val(st() & 128'h6, 128'h0);
    // paused erase refuses a security erase
    array_op_is_erase = 1'b1;
    pulse(1);
    send(64'h75, 8, 0);
    pulse(0);
    send(64'h44001000, 32, 0);
    check_val(st() & 128'hE, 128'hC);
    // host lets the paused erase finish before any reset
    send(64'h7A, 8, 0);
    check_val(st() & 128'h6, 128'h2);
    pulse(2);
    check_val(st() & 128'h6, 128'h0);
    pulse(0);
    // reset pair split by another frame is not taken, an adjacent pair is
    send(64'h66, 8, 0);
    send(64'h9F, 8, 0);
    send(64'h99, 8, 0);
    check_val(128'(n_rst), 128'h0);
    send(64'h66, 8, 0);
    send(64'h99, 8, 0);
    check_val(128'(n_rst), 128'h1);
    check_val(st(), 128'h10);
    // an enable-reset sent during recovery is refused
    send(64'h66, 8, 0);
    repeat (150) step();
    send(64'h99, 8, 0);
    check_val(128'(n_rst), 128'h1);
    complete_run();
  end
  // watchdog well past the expected run of under a millisecond
  initial
  begin
    #(3000000);
    mismatches++;
    complete_run();
  end
endmodule
